// [rtl/qdw_write_decoder.v]
// Serial bus slave receiver write path of a quad 10-bit converter.
// Assumes bus pins sampled on ref_clk_in well above bus clock rate.
//
// Contract
// - A write opens with start, address 1,0,0,1,1,select bits,write bit 0; address, control and data bytes are acked.
// - The byte after the address is the control byte setting mode and channel.
// - Control bit 0 marks following bytes as power-down data when set, conversion data when clear.
// - In data mode high/low byte pairs are taken until stop or repeated start.
// - In power-down mode exactly two bytes are taken, then master ends the transfer.
// - High byte holds data bits 9..2, low byte holds bits 1..0 on top, rest ignored.
// - A channel update applies at the falling clock edge of the ack after the low byte.
// - Load code 00 holds only, 01 also loads the channel output, 10 also loads all outputs.
// - Load code 11 is a broadcast; with select bit 1 at 0 all outputs load from held data.
`timescale 1ns/10ps
`default_nettype none
`include "qdw_regs.vh"
module qdw_write_decoder (
    input wire ref_clk_in,
    input wire rstn_in,
    input wire scl_in,
    input wire sda_in,
    input wire addr_select_high_in,
    input wire addr_select_low_in,
    output reg sda_out,
    output reg sda_oe_out,
    output reg [47:0] channel_holding_register_out,
    output reg [47:0] channel_output_register_out,
    output reg update_out
);
    localparam ST_IDLE = 5'h01;
    localparam ST_ADDR = 5'h02;
    localparam ST_CTRL = 5'h04;
    localparam ST_DATA = 5'h08;
    localparam ST_SKIP = 5'h10;
    wire scl_s;
    wire sda_s;
    wire addr_high_s;
    wire addr_low_s;
    reg scl_d_r;
    reg sda_d_r;
    reg [4:0] state_r;
    reg [3:0] bit_cnt_r;
    reg [7:0] shift_r;
    reg ack_r;
    reg ack_seen_r;
    reg [7:0] ctrl_r;
    reg [7:0] hi_r;
    reg low_phase_r;
    reg pd_done_r;
    reg pend_r;
    reg [9:0] pend_data_r;
    reg [1:0] pend_pd_r;
    reg bcast_r;
    integer i;

    qdw_sync u_scl (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .pin_in(scl_in),
        .level_out(scl_s)
    );
    qdw_sync u_sda (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .pin_in(sda_in),
        .level_out(sda_s)
    );
    // Straps are pins as well, so they get the same filter
    qdw_sync u_ash (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .pin_in(addr_select_high_in),
        .level_out(addr_high_s)
    );
    qdw_sync u_asl (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .pin_in(addr_select_low_in),
        .level_out(addr_low_s)
    );

    wire scl_rise = scl_s & ~scl_d_r;
    wire scl_fall = ~scl_s & scl_d_r;
    wire start_det = scl_s & scl_d_r & ~sda_s & sda_d_r;
    wire stop_det = scl_s & scl_d_r & sda_s & ~sda_d_r;
    wire [7:0] rx_byte = {shift_r[6:0], sda_s};
    wire [1:0] load_mode = ctrl_r[`QDW_CTRL_LOAD_LSB+1:`QDW_CTRL_LOAD_LSB];
    wire [1:0] ch_sel = ctrl_r[`QDW_CTRL_CH_LSB+1:`QDW_CTRL_CH_LSB];

    // Address match: fixed part, own select pins, write direction
    function addr_ok;
        input [7:0] b;
        input a1;
        input a0;
        begin
            addr_ok = (b[7:3] == `QDW_ADDR_FIXED) && (b[2] == a1) && (b[1] == a0) && !b[0];
        end
    endfunction

    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            state_r <= ST_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            ack_r <= 1'b0;
            ack_seen_r <= 1'b0;
            ctrl_r <= 8'h00;
            hi_r <= 8'h00;
            low_phase_r <= 1'b0;
            pd_done_r <= 1'b0;
            pend_r <= 1'b0;
            pend_data_r <= 10'h000;
            pend_pd_r <= 2'h0;
            bcast_r <= 1'b0;
            sda_out <= 1'b0;
            sda_oe_out <= 1'b0;
            channel_holding_register_out <= 48'h000000000000;
            channel_output_register_out <= 48'h000000000000;
            update_out <= 1'b0;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
            update_out <= 1'b0;
            sda_out <= 1'b0;
            if (start_det) begin
                // Repeated start ends any stream and re-reads the address
                state_r <= ST_ADDR;
                bit_cnt_r <= 4'h0;
                ack_r <= 1'b0;
                sda_oe_out <= 1'b0;
                pend_r <= 1'b0;
            end else if (stop_det) begin
                state_r <= ST_IDLE;
                sda_oe_out <= 1'b0;
                ack_r <= 1'b0;
                pend_r <= 1'b0;
            end else if (scl_rise && !ack_r && state_r != ST_IDLE && state_r != ST_SKIP) begin
                shift_r <= rx_byte;
                bit_cnt_r <= bit_cnt_r + 4'h1;
                if (bit_cnt_r == 4'h7) begin
                    bit_cnt_r <= 4'h0;
                    ack_r <= 1'b1;
                    ack_seen_r <= 1'b0;
                    case (state_r)
                        ST_ADDR: begin
                            if (addr_ok(rx_byte, addr_high_s, addr_low_s)) begin
                                state_r <= ST_CTRL;
                            end else begin
                                // Not ours: stay released until next start
                                state_r <= ST_SKIP;
                                ack_r <= 1'b0;
                            end
                        end
                        ST_CTRL: begin
                            ctrl_r <= rx_byte;
                            low_phase_r <= 1'b0;
                            pd_done_r <= 1'b0;
                            state_r <= ST_DATA;
                            // Broadcast refresh needs no data bytes
                            bcast_r <= (rx_byte[5:4] == `QDW_LOAD_BCAST) && !rx_byte[2];
                        end
                        ST_DATA: begin
                            if (pd_done_r) begin
                                // Extra bytes after power-down word go unacked
                                ack_r <= 1'b0;
                                state_r <= ST_SKIP;
                            end else if (!low_phase_r) begin
                                hi_r <= rx_byte;
                                low_phase_r <= 1'b1;
                            end else begin
                                low_phase_r <= 1'b0;
                                pend_r <= 1'b1;
                                pend_data_r <= {hi_r, rx_byte[7:6]};
                                pend_pd_r <= ctrl_r[`QDW_CTRL_PD_BIT] ? hi_r[7:6] : 2'h0;
                                pd_done_r <= ctrl_r[`QDW_CTRL_PD_BIT];
                            end
                        end
                        default: begin
                            state_r <= ST_IDLE;
                        end
                    endcase
                end
            end else if (scl_fall && ack_r) begin
                if (!ack_seen_r) begin
                    // Drive ack low for the ninth clock
                    sda_oe_out <= 1'b1;
                    ack_seen_r <= 1'b1;
                    if (bcast_r) begin
                        bcast_r <= 1'b0;
                        channel_output_register_out <= channel_holding_register_out;
                        update_out <= 1'b1;
                    end
                end else begin
                    sda_oe_out <= 1'b0;
                    ack_r <= 1'b0;
                    if (pend_r) begin
                        // Applied at the falling edge that ends the ack
                        pend_r <= 1'b0;
                        update_out <= 1'b1;
                        for (i = 0; i < `QDW_CH_COUNT; i = i + 1) begin
                            if (load_mode == `QDW_LOAD_BCAST || i == ch_sel) begin
                                channel_holding_register_out[i*12 +: 12] <= {pend_pd_r, pend_data_r};
                            end
                            if (load_mode == `QDW_LOAD_BCAST || (load_mode == `QDW_LOAD_ONE && i == ch_sel)) begin
                                channel_output_register_out[i*12 +: 12] <= {pend_pd_r, pend_data_r};
                            end else if (load_mode == `QDW_LOAD_ALL) begin
                                channel_output_register_out[i*12 +: 12] <= (i == ch_sel) ?
                                    {pend_pd_r, pend_data_r} : channel_holding_register_out[i*12 +: 12];
                            end
                        end
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// [rtl/qdw_regs.vh]
// Constants for the quad converter serial write decoder.
// Assumes inclusion by the design files under rtl/.
`ifndef QDW_REGS_VH
`define QDW_REGS_VH
`define QDW_ADDR_FIXED 5'h13
`define QDW_CTRL_PD_BIT 0
`define QDW_CTRL_CH_LSB 1
`define QDW_CTRL_LOAD_LSB 4
`define QDW_LOAD_HOLD 2'h0
`define QDW_LOAD_ONE 2'h1
`define QDW_LOAD_ALL 2'h2
`define QDW_LOAD_BCAST 2'h3
`define QDW_CH_COUNT 4
`define QDW_REG_W 12
`endif

// [rtl/qdw_sync.v]
// Three-stage synchroniser with agreement filter for one pin.
// Assumes the pin is asynchronous to ref_clk_in.
`timescale 1ns/10ps
`default_nettype none
module qdw_sync (
    input wire ref_clk_in,
    input wire rstn_in,
    input wire pin_in,
    output reg level_out
);
    reg s1_r;
    reg s2_r;
    reg s3_r;
    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
            s3_r <= 1'b1;
            level_out <= 1'b1;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // Change only once stages two and three agree
            if (s2_r == s3_r) begin
                level_out <= s3_r;
            end
        end
    end
endmodule
`default_nettype wire

// [dv/qdw_checker.sv]
// Checker on the write decoder's bus pins and result registers.
// Assumes the bench holds SCL low for over ten clocks per phase.
`timescale 1ns/10ps
`default_nettype none
module qdw_checker (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic addr_select_high_in,
    input wire logic addr_select_low_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    input wire logic [47:0] channel_holding_register_out,
    input wire logic [47:0] channel_output_register_out,
    input wire logic update_out
);
    wire [47:0] h = channel_holding_register_out;
    wire [47:0] o = channel_output_register_out;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    property p_ack_low; sda_oe_out |-> !sda_out; endproperty
    a_ack_low: assert property (p_ack_low) else $error("ack level wrong");
    property p_ack_stand; $rose(sda_oe_out) |=> sda_oe_out [*3]; endproperty
    a_ack_stand: assert property (p_ack_stand) else $error("ack too short");
    property p_oe_scl; $changed(sda_oe_out) |-> !scl_in; endproperty
    a_oe_scl: assert property (p_oe_scl) else $error("ack moved with clock high");
    property p_upd_pulse; update_out |=> !update_out; endproperty
    a_upd_pulse: assert property (p_upd_pulse) else $error("update too long");
    property p_upd_scl; update_out |-> !scl_in; endproperty
    a_upd_scl: assert property (p_upd_scl) else $error("update with clock high");
    property p_hold_upd; $changed(h) |-> update_out || $past(update_out); endproperty
    a_hold_upd: assert property (p_hold_upd) else $error("holding changed silently");
    property p_out_upd; $changed(o) |-> update_out || $past(update_out); endproperty
    a_out_upd: assert property (p_out_upd) else $error("output changed silently");
    property p_out_follow; $changed(o[11:0]) |-> o[11:0] == h[11:0]; endproperty
    a_out_follow: assert property (p_out_follow) else $error("output not from holding");
    c_upd: cover property (update_out);
    c_ack: cover property ($rose(sda_oe_out));
    c_out: cover property ($changed(o));
endmodule
bind qdw_write_decoder qdw_checker u_chk (.ref_clk_in, .rstn_in, .scl_in, .sda_in, .addr_select_high_in,
    .addr_select_low_in, .sda_out, .sda_oe_out, .channel_holding_register_out, .channel_output_register_out,
    .update_out);
`default_nettype wire

// [dv/qdw_master.sv]
// Bus master model: drives SCL and pulls SDA low.
// Assumes a pull-up on SDA; ten clocks per phase.
`timescale 1ns/10ps
`default_nettype none
module qdw_master (
    input wire logic clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_low_out
);
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    // Works from idle and as repeated start
    task automatic start();
        sda_low_out = 1'b0;
        wt(10);
        scl_out = 1'b1;
        wt(10);
        sda_low_out = 1'b1;
        wt(10);
        scl_out = 1'b0;
        wt(10);
    endtask
    task automatic stop();
        sda_low_out = 1'b1;
        wt(10);
        scl_out = 1'b1;
        wt(10);
        sda_low_out = 1'b0;
        wt(10);
    endtask
    // SDA only moves while SCL is low
    task automatic bit_out(input logic l, output logic v);
        sda_low_out = l;
        wt(10);
        scl_out = 1'b1;
        wt(10);
        v = sda_in;
        scl_out = 1'b0;
        wt(10);
    endtask
    task automatic put(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) bit_out(!b[i], ack);
        bit_out(1'b0, ack);
        ack = !ack;
    endtask
endmodule
`default_nettype wire

// [dv/qdw_write_decoder_tb_top.sv]
// Bench: random writes through the master model against a channel model.
// Assumes qdw_master and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module qdw_write_decoder_tb_top;
    logic ref_clk_in = 1'b0, rstn_in = 1'b0, ash = 1'b0, asl = 1'b0, a;
    wire scl, low, oe, upd, sdo, sda_w;
    wire [47:0] h, o;
    logic [11:0] hold [4], outp [4], mh [4], mo [4];
    int miscompares = 0, samples_checked = 0;
    int upd_cnt = 0;
    assign sda_w = !low && !(oe && !sdo);
    initial forever #5 ref_clk_in = !ref_clk_in;
    // Update pulses are one cycle wide, so each edge sample counts once
    always @(posedge ref_clk_in) if (upd === 1'b1) upd_cnt++;
    qdw_master u_mst (.clk_in(ref_clk_in), .sda_in(sda_w), .scl_out(scl), .sda_low_out(low));
    qdw_write_decoder u_dut (.ref_clk_in, .rstn_in, .scl_in(scl), .sda_in(sda_w), .addr_select_high_in(ash),
        .addr_select_low_in(asl), .sda_out(sdo), .sda_oe_out(oe), .channel_holding_register_out(h),
        .channel_output_register_out(o), .update_out(upd));
    task automatic chk(input string n, input logic [11:0] s, input logic [11:0] e);
        samples_checked++;
        if (s !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic close_out();
        $display("Checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic load(input int ld, input int ch);
        for (int k = 0; k < 4; k++) if (ld > 1 || (ld == 1 && k == ch)) begin
            outp[k] = hold[k];
            mo[k] = mh[k];
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] c, input int n);
        logic [9:0] d;
        logic ok;
        int upd_base;
        ok = ad == {5'h13, ash, asl, 1'b0};
        upd_base = upd_cnt;
        u_mst.start();
        u_mst.put(ad, a);
        chk("addr ack", a, ok);
        if (ok) begin
            u_mst.put(c, a);
            chk("ctrl ack", a, 1'b1);
            if (n == 0) load(2, 0);
            for (int i = 0; i < n; i++) begin
                d = 10'($urandom);
                u_mst.put(c[0] ? {d[1:0], 6'h0} : d[9:2], a);
                chk("high ack", a, 1'b1);
                u_mst.put(c[0] ? {2'h0, d[5:0]} : {d[1:0], d[7:2]}, a);
                chk("low ack", a, 1'b1);
                for (int k = 0; k < 4; k++) if (c[5:4] == 2'h3 || k == c[2:1]) begin
                    hold[k] = c[0] ? {d[1:0], 10'h0} : {2'h0, d};
                    mh[k] = c[0] ? 12'hc00 : 12'hfff;
                end
                load(c[5:4], c[2:1]);
            end
            if (c[0] && n > 0) u_mst.put(8'h0, a);
            if (c[0] && n > 0) chk("extra ack", a, 1'b0);
        end
        if (!ok || $urandom % 2) u_mst.stop();
        for (int k = 0; k < 4; k++) begin
            chk("hold", h[k*12+:12] & mh[k], hold[k] & mh[k]);
            chk("out", o[k*12+:12] & mo[k], outp[k] & mo[k]);
        end
        chk("updates", 12'(upd_cnt - upd_base), 12'(ok ? ((n == 0) ? 1 : n) : 0));
    endtask
    initial begin
        for (int k = 0; k < 4; k++) begin
            hold[k] = 12'h0;
            outp[k] = 12'h0;
            mh[k] = 12'hfff;
            mo[k] = 12'hfff;
        end
        void'($urandom(32'h3610));
        repeat (3) @(posedge ref_clk_in);
        #1 rstn_in = 1'b1;
        for (int i = 0; i < 20; i++) begin
            logic [7:0] ad, c;
            ash = 1'($urandom);
            asl = 1'($urandom);
            ad = {5'h13, ash, asl, 1'b0} ^ ((i % 5 == 4) ? 8'h1 << ($urandom % 8) : 8'h0);
            c = {2'h0, 2'(i), 1'($urandom), 2'($urandom), 1'(i / 4)};
            // Power-down takes exactly one pair; data may stream several
            wr(ad, c, (c[5:4] == 2'h3 && !c[2]) ? 0 : (c[0] ? 1 : 1 + $urandom % 3));
        end
        close_out();
    end
endmodule
`default_nettype wire
